// file: rtl/fpm_defs.svh
// Purpose: bit positions and constants of the accelerator mode control word
// Assumes: included by its bare name from rtl files
// Notes:   positions follow the 64-bit mode word layout
`ifndef FPM_DEFS_SVH
`define FPM_DEFS_SVH
`define FPM_MODE_RESET      64'h0000_0000_0000_0000
`define FPM_RSV_MASK        64'hFFFF_8000_F02E_0400
`define FPM_BIT_PIN_GATE    46
`define FPM_BIT_HALT        45
`define FPM_BIT_ADVANCE     44
`define FPM_MOVE_HI         43
`define FPM_MOVE_LO         40
`define FPM_MAC_HI          39
`define FPM_MAC_LO          36
`define FPM_STAGE_HI        35
`define FPM_STAGE_LO        32
`define FPM_MASK_HI         27
`define FPM_MASK_LO         22
`define FPM_BIT_PIPE        20
`define FPM_ROUND_HI        16
`define FPM_ROUND_LO        14
`define FPM_PROD_HI         13
`define FPM_PROD_LO         12
`define FPM_BIT_SIGNED      11
`define FPM_BIT_HEX_BIAS    9
`define FPM_BIT_HEX_KEEP    8
`define FPM_BIT_FLUSH       7
`define FPM_BIT_TRAP        6
`define FPM_BIT_AFFINE      5
`define FPM_BIT_CLAMP       4
`define FPM_ALT_HI          3
`define FPM_ALT_LO          2
`define FPM_PRI_HI          1
`define FPM_PRI_LO          0
`define FPM_HEX_BIAS_ADJ    8'h80
`define FPM_TRAP_ADJ_SGL    12'h0C0
`define FPM_TRAP_ADJ_DBL    12'h600
`define FPM_STATUS_ES_BIT   6
`endif

// file: rtl/fpm_pkg.sv
// Purpose: shared types of the accelerator mode control block
// Assumes: fpm_defs.svh holds the numeric constants
// Notes:   decoded mode travels as one packed struct
package fpm_pkg;
  typedef enum logic [5:0] {
    FPM_SEL_RESULT = 6'b00_0001,
    FPM_SEL_FLAGS  = 6'b00_0010,
    FPM_SEL_STATUS = 6'b00_0100,
    FPM_SEL_INSTR  = 6'b00_1000,
    FPM_SEL_MODE   = 6'b01_0000,
    FPM_SEL_PREC   = 6'b10_0000
  } fpm_sel_e;
  typedef enum logic [2:0] {
    FPM_RND_NEAR = 3'h0, FPM_RND_MINF = 3'h1, FPM_RND_PINF = 3'h2,
    FPM_RND_ZERO = 3'h3, FPM_RND_ALTN = 3'h4, FPM_RND_AWAY = 3'h5
  } fpm_round_e;
  typedef enum logic [1:0] {
    FPM_FMT_IEEE = 2'h0, FPM_FMT_ALT1 = 2'h1, FPM_FMT_ALT2 = 2'h2, FPM_FMT_HEX = 2'h3
  } fpm_fmt_e;
  typedef struct packed {
    logic       fault_pin_gate;
    logic       halt_on_fault;
    logic       advance_ready;
    logic [3:0] move_cycle_count;
    logic [3:0] mac_cycle_count;
    logic [3:0] stage_cycle_count;
    logic [5:0] fault_masks;
    logic       pipelined_select;
    logic [2:0] rounding_select;
    logic [1:0] product_window_select;
    logic       signed_multiply;
    logic       hex_underflow_bias;
    logic       hex_significance_keep;
    logic       flush_denormals;
    logic       ieee_trap_enable;
    logic       infinity_closure_select;
    logic       overflow_clamp;
    logic [1:0] alternate_format;
    logic [1:0] primary_format;
  } fpm_mode_s;
  typedef enum logic [2:0] {
    FPM_OP_MOVE  = 3'b001,
    FPM_OP_MAC   = 3'b010,
    FPM_OP_OTHER = 3'b100
  } fpm_op_e;
endpackage : fpm_pkg

// file: rtl/fpm_out_mux.sv
// Purpose: result bus selector of the accelerator
// Assumes: select is one-hot, from the same clock
// Notes:   registered so the bus comes straight from a flip-flop
module fpm_out_mux
  import fpm_pkg::*;
(
  // clock and reset
  input  wire logic            clk_sys_i,
  input  wire logic            rst_b_i,
  // sources
  input  wire fpm_pkg::fpm_sel_e sel_i,
  input  wire logic [31:0]     result_i,
  input  wire logic [31:0]     flags_i,
  input  wire logic [31:0]     status_i,
  input  wire logic [31:0]     instr_i,
  input  wire logic [31:0]     mode_i,
  input  wire logic [31:0]     prec_i,
  // result bus
  output logic      [31:0]     bus_o
);
  // one register stage; unknown selects return zero
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      bus_o <= 32'h0000_0000;
    end
    else
    begin
      case (sel_i)
        FPM_SEL_RESULT: bus_o <= result_i;
        FPM_SEL_FLAGS:  bus_o <= flags_i;
        FPM_SEL_STATUS: bus_o <= status_i;
        FPM_SEL_INSTR:  bus_o <= instr_i;
        FPM_SEL_MODE:   bus_o <= mode_i;
        FPM_SEL_PREC:   bus_o <= prec_i;
        default:        bus_o <= 32'h0000_0000;
      endcase
    end
  end
endmodule // fpm_out_mux

// file: rtl/fpm_mode_ctrl.sv
// Purpose: mode word storage, decode, fault reporting and ALU timing of the accelerator
// Assumes: transaction decode upstream gives one-cycle write strobes on clk_sys_i
// Notes:   the ALU itself is outside; this block only steers it
`include "fpm_defs.svh"

module fpm_mode_ctrl
  import fpm_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_b_i,
  // mode write request
  input  wire logic                 mode_wr_i,
  input  wire logic [63:0]          mode_data_i,
  // operation launch from the control unit
  input  wire logic                 op_start_i,
  input  wire fpm_pkg::fpm_op_e     op_kind_i,
  // exception bits of the status register, bits 5..0
  input  wire logic [5:0]           status_faults_i,
  // result bus sources
  input  wire fpm_pkg::fpm_sel_e    out_sel_i,
  input  wire logic [31:0]          result_i,
  input  wire logic [31:0]          flags_i,
  input  wire logic [31:0]          status_i,
  input  wire logic [31:0]          instr_i,
  input  wire logic                 mode_half_i,
  input  wire logic [31:0]          prec_i,
  // decoded mode and reporting
  output fpm_pkg::fpm_mode_s        mode_o,
  output logic                      exception_summary_o,
  output logic                      fault_pin_n_o,
  output logic                      halted_o,
  output logic                      busy_o,
  output logic                      result_ready_n_o,
  output logic [31:0]               result_bus_o
);
  import fpm_pkg::*;

  logic [63:0] mode_q;
  logic [3:0]  cnt_q;
  logic [3:0]  cnt_d;
  logic        fault_now;
  logic [5:0]  fault_live;

  // decode the word into named fields; pure wiring so it acts at once
  function automatic fpm_mode_s fpm_decode(input logic [63:0] w);
    fpm_mode_s m;
    m.fault_pin_gate          = w[`FPM_BIT_PIN_GATE];
    m.halt_on_fault           = w[`FPM_BIT_HALT];
    m.advance_ready           = w[`FPM_BIT_ADVANCE];
    m.move_cycle_count        = w[`FPM_MOVE_HI:`FPM_MOVE_LO];
    m.mac_cycle_count         = w[`FPM_MAC_HI:`FPM_MAC_LO];
    m.stage_cycle_count       = w[`FPM_STAGE_HI:`FPM_STAGE_LO];
    m.fault_masks             = w[`FPM_MASK_HI:`FPM_MASK_LO];
    m.pipelined_select        = w[`FPM_BIT_PIPE];
    m.rounding_select         = w[`FPM_ROUND_HI:`FPM_ROUND_LO];
    m.product_window_select   = w[`FPM_PROD_HI:`FPM_PROD_LO];
    m.signed_multiply         = w[`FPM_BIT_SIGNED];
    m.hex_underflow_bias      = w[`FPM_BIT_HEX_BIAS];
    m.hex_significance_keep   = w[`FPM_BIT_HEX_KEEP];
    m.flush_denormals         = w[`FPM_BIT_FLUSH];
    m.ieee_trap_enable        = w[`FPM_BIT_TRAP];
    m.infinity_closure_select = w[`FPM_BIT_AFFINE];
    m.overflow_clamp          = w[`FPM_BIT_CLAMP];
    m.alternate_format        = w[`FPM_ALT_HI:`FPM_ALT_LO];
    m.primary_format          = w[`FPM_PRI_HI:`FPM_PRI_LO];
    return m;
  endfunction

  fpm_mode_s mode_c;
  assign mode_c = fpm_decode(mode_q);

  // the word on the request lines steers everything in its own write cycle;
  // waiting for the stored copy would add a cycle in which the old masks still act
  fpm_mode_s mode_now;
  assign mode_now = mode_wr_i ? fpm_decode(mode_data_i) : mode_c;

  // the only writer of the mode word is the host request; reserved bits are stored as written
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mode_q <= `FPM_MODE_RESET;
    end
    else if (mode_wr_i)
    begin
      mode_q <= mode_data_i;
    end
  end

  // registered copy of the decoded fields for the datapath
  // the datapath sees the incoming word one cycle after the write cycle, when mode_o takes it
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      mode_o <= fpm_decode(`FPM_MODE_RESET);
    end
    else
    begin
      mode_o <= mode_now;
    end
  end

  // a fault counts only when its mask bit is clear; bit order of masks matches status bits
  // masks 27..22 are zero,inexact,underflow,overflow,reserved,invalid = status 5..0
  // one gate per status bit, so a mask only ever hides its own exception
  for (genvar g = 0; g < 6; g++)
  begin : g_fault
    assign fault_live[g] = status_faults_i[g] & ~mode_now.fault_masks[g];
  end

  // any surviving bit makes an error condition
  assign fault_now = |fault_live;

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      exception_summary_o <= 1'b0;
    end
    else
    begin
      exception_summary_o <= fault_now;
    end
  end

  // active-low pin; a clear gate bit forces it inactive high
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      fault_pin_n_o <= 1'b1;
    end
    else
    begin
      fault_pin_n_o <= ~(fault_now & mode_now.fault_pin_gate);
    end
  end

  // halt while an unmasked fault stands; clears when software clears the status bit
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      halted_o <= 1'b0;
    end
    else
    begin
      halted_o <= fault_now & mode_now.halt_on_fault;
    end
  end

  // traversal timer: load count per op kind, count down to zero
  // out-of-range counts are not trapped; the host keeps them legal
  function automatic logic [3:0] fpm_load(input fpm_mode_s m, input fpm_op_e k);
    logic [3:0] c;
    c = m.stage_cycle_count;
    if (m.pipelined_select)
    begin
      c = m.stage_cycle_count;
    end
    else if (k == FPM_OP_MOVE)
    begin
      c = m.move_cycle_count;
    end
    else if (k == FPM_OP_MAC)
    begin
      c = m.mac_cycle_count;
    end
    return c;
  endfunction

  always_comb
  begin
    cnt_d = cnt_q;
    if (cnt_q != 4'h0)
    begin
      cnt_d = cnt_q - 4'h1;
    end
    else if (op_start_i && !(fault_now && mode_now.halt_on_fault))
    begin
      cnt_d = fpm_load(mode_now, op_kind_i);
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_q <= 4'h0;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  // busy follows the next counter value so it rises in the cycle after launch;
  // a start that arrives while busy is dropped, the host must wait for ready
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      busy_o <= 1'b0;
    end
    else
    begin
      busy_o <= (cnt_d != 4'h0);
    end
  end

  // ready low for one cycle at the end; advanced one cycle only in flow-through
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      result_ready_n_o <= 1'b1;
    end
    else if (mode_now.advance_ready && !mode_now.pipelined_select)
    begin
      result_ready_n_o <= ~(cnt_q == 4'h2);
    end
    else
    begin
      // pipeline mode ends one stage count after launch, the advance bit is ignored there
      result_ready_n_o <= ~(cnt_q == 4'h1);
    end
  end

  // mode readout on the 32-bit bus takes one half per read
  fpm_out_mux u_out_mux (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .sel_i     (out_sel_i),
    .result_i  (result_i),
    .flags_i   (flags_i),
    .status_i  (status_i),
    .instr_i   (instr_i),
    .mode_i    (mode_half_i ? mode_q[63:32] : mode_q[31:0]),
    .prec_i    (prec_i),
    .bus_o     (result_bus_o)
  );
endmodule // fpm_mode_ctrl

// file: sim/fpm_mode_chk.sv
// Purpose: port checks of the mode control block
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   timer fields are taken to be in their legal ranges
module fpm_mode_chk
  import fpm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_b_i,
  // requests
  input wire logic mode_wr_i,
  input wire logic [63:0] mode_data_i,
  input wire logic op_start_i,
  input wire fpm_pkg::fpm_op_e op_kind_i,
  input wire logic [5:0] status_faults_i,
  // reporting
  input wire fpm_pkg::fpm_mode_s mode_o,
  input wire logic exception_summary_o,
  input wire logic fault_pin_n_o,
  input wire logic halted_o,
  input wire logic busy_o,
  input wire logic result_ready_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i);
  logic [37:0] pk;
  logic fault;
  logic acc;
  logic [3:0] exp_q;
  logic [3:0] len_q;
  // packed image of the stored fields, reserved positions dropped
  assign pk = {mode_data_i[46:32], mode_data_i[27:22], mode_data_i[20], mode_data_i[16:11], mode_data_i[9:0]};
  assign fault = |(status_faults_i & ~mode_o.fault_masks);
  assign acc = op_start_i && !busy_o && !halted_o;
  // span latched at launch, so a wrong timer field shows as a length error
  always_ff @(posedge clk_sys_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      exp_q <= 4'h0;
      len_q <= 4'h0;
    end
    else if (acc)
    begin
      len_q <= 4'h0;
      exp_q <= (mode_o.pipelined_select || op_kind_i == FPM_OP_OTHER) ? mode_o.stage_cycle_count :
               (op_kind_i == FPM_OP_MOVE) ? mode_o.move_cycle_count : mode_o.mac_cycle_count;
    end
    else if (busy_o)
      len_q <= len_q + 4'h1;
  chk_mode_load: assert property (mode_wr_i |=> mode_o == $past(pk)) else $error("mode not loaded");
  chk_mode_hold: assert property (!mode_wr_i |=> $stable(mode_o)) else $error("mode changed");
  chk_pin_gate: assert property (!mode_wr_i |=> fault_pin_n_o == !($past(fault) && mode_o.fault_pin_gate))
    else $error("fault pin wrong");
  chk_halt_gate: assert property (!mode_wr_i |=> halted_o == ($past(fault) && mode_o.halt_on_fault))
    else $error("halt wrong");
  chk_summary_mask: assert property (!mode_wr_i |=> exception_summary_o == $past(fault))
    else $error("summary wrong");
  chk_halt_block: assert property (fault && mode_o.halt_on_fault && halted_o && op_start_i && !busy_o |=> !busy_o)
    else $error("start while halted");
  chk_busy_span: assert property ($fell(busy_o) |-> len_q == exp_q) else $error("busy span wrong");
  chk_ready_pulse: assert property ($fell(result_ready_n_o) |=> result_ready_n_o) else $error("ready too long");
endmodule // fpm_mode_chk
bind fpm_mode_ctrl fpm_mode_chk i_fpm_mode_chk (.clk_sys_i, .rst_b_i, .mode_wr_i, .mode_data_i, .op_start_i,
  .op_kind_i, .status_faults_i, .mode_o, .exception_summary_o, .fault_pin_n_o, .halted_o, .busy_o, .result_ready_n_o);

// file: sim/fpm_host.sv
// Purpose: host model issuing write-mode requests
// Assumes: requests change on the falling edge
// Notes:   one idle cycle between writes
`include "fpm_defs.svh"
module fpm_host (
  // clock
  input wire logic clk_sys_i,
  // write-mode request
  output logic mode_wr_o,
  output logic [63:0] mode_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial mode_wr_o = 1'b0;
  initial mode_data_o = 64'h0;
  // one-cycle strobe; data inverted after, so a stale word is never reused
  task automatic write_mode(input logic [63:0] w);
    @(negedge clk_sys_i);
    mode_wr_o = 1'b1;
    mode_data_o = w & ~`FPM_RSV_MASK;
    @(negedge clk_sys_i);
    mode_wr_o = 1'b0;
    mode_data_o = ~mode_data_o;
  endtask
endmodule // fpm_host

// file: sim/fp_accelerator_mode_control_bench.sv
// Purpose: self-checking bench of the mode control block
// Assumes: inputs change on the falling edge
// Notes:   timer fields kept in their legal ranges
module fp_accelerator_mode_control_bench
  import fpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic mode_wr;
  logic [63:0] mode_data;
  logic op_start = 1'b0;
  logic mode_half = 1'b0;
  fpm_op_e op_kind = FPM_OP_MOVE;
  fpm_sel_e sel = FPM_SEL_RESULT;
  logic [5:0] faults = 6'h00;
  logic [31:0] src [6] = '{32'h1111_0001, 32'h2222_0002, 32'h3333_0003, 32'h4444_0004, 32'h0, 32'h6666_0006};
  fpm_mode_s mode;
  logic summ, pin_n, halted, busy, rdy_n;
  logic [31:0] bus;
  logic [63:0] w;
  int n_mismatch = 0;
  int cmp_count = 0;
  int nb, nr, nr0;
  // 25 MHz system clock
  always #20 clk_sys_i = ~clk_sys_i;
  fpm_host i_fpm_host (.clk_sys_i, .mode_wr_o(mode_wr), .mode_data_o(mode_data));
  fpm_mode_ctrl i_fpm_mode_ctrl (.clk_sys_i, .rst_b_i, .mode_wr_i(mode_wr), .mode_data_i(mode_data),
    .op_start_i(op_start), .op_kind_i(op_kind), .status_faults_i(faults), .out_sel_i(sel), .result_i(src[0]),
    .flags_i(src[1]), .status_i(src[2]), .instr_i(src[3]), .mode_half_i(mode_half), .prec_i(src[5]),
    .mode_o(mode), .exception_summary_o(summ), .fault_pin_n_o(pin_n), .halted_o(halted), .busy_o(busy),
    .result_ready_n_o(rdy_n), .result_bus_o(bus));
  // word compare; case inequality so unknowns never match
  task automatic cmp_w(input logic [63:0] got, input logic [63:0] exp, input string msg);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t ns: %s", $time, msg);
    end
  endtask
  // flag compare
  task automatic cmp_b(input logic got, input logic exp, input string msg);
    cmp_w({63'h0, got}, {63'h0, exp}, msg);
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  // launch one operation, count busy cycles and note where ready falls
  task automatic run_op(input fpm_op_e k);
    nb = 0;
    nr = 0;
    op_kind = k;
    op_start = 1'b1;
    tick(1);
    op_start = 1'b0;
    for (int i = 1; i <= 20; i++)
    begin
      if (busy === 1'b1) nb++;
      if (rdy_n === 1'b0) nr = i;
      tick(1);
    end
  endtask
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // watchdog: tests need some 180 cycles, give them far more
  initial
  begin
    #200_000;
    n_mismatch++;
    complete_run();
  end
  // test sequence
  initial
  begin
    tick(6);
    rst_b_i = 1'b1;
    tick(1);
    cmp_w(64'(mode), 64'h0, "mode after reset");
    cmp_b(pin_n, 1'b1, "pin after reset");
    cmp_b(busy, 1'b0, "busy after reset");
    $display("test reset done");
    for (int r = 0; r < 6; r++)
    begin
      w = 64'h0000_0357_0000_0000 | (64'(r) << 14) | (64'(r % 4) << 12);
      i_fpm_host.write_mode(w);
      cmp_w(64'(mode.rounding_select), 64'(r), "rounding field");
      cmp_w(64'(mode.product_window_select), 64'(r % 4), "product field");
    end
    i_fpm_host.write_mode(64'h0000_0357_0000_0BFF);
    cmp_b(mode.signed_multiply, 1'b1, "signed multiply");
    cmp_b(mode.hex_underflow_bias, 1'b1, "hex underflow bias");
    cmp_b(mode.hex_significance_keep, 1'b1, "hex significance");
    cmp_b(mode.flush_denormals, 1'b1, "flush denormals");
    cmp_b(mode.ieee_trap_enable, 1'b1, "trap enable");
    cmp_b(mode.infinity_closure_select, 1'b1, "affine select");
    cmp_b(mode.overflow_clamp, 1'b1, "overflow clamp");
    cmp_w(64'({mode.alternate_format, mode.primary_format}), 64'hF, "formats");
    sel = FPM_SEL_MODE;
    mode_half = 1'b1;
    tick(2);
    cmp_w(64'(bus), 64'h0357, "mode high half");
    mode_half = 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      sel = fpm_sel_e'(6'h01 << i);
      src[i] = src[i] ^ 32'h00F0_00F0;
      tick(2);
      cmp_w(64'(bus), (i == 4) ? 64'h0BFF : 64'(src[i]), "bus source");
    end
    sel = fpm_sel_e'(6'h00);
    tick(2);
    cmp_w(64'(bus), 64'h0, "no source selected");
    $display("test fields and bus done");
    i_fpm_host.write_mode(64'h0000_0357_0000_0000);
    run_op(FPM_OP_MOVE);
    nr0 = nr;
    cmp_w(64'(nb), 64'h3, "move span");
    run_op(FPM_OP_MAC);
    cmp_w(64'(nb), 64'h5, "mac span");
    run_op(FPM_OP_OTHER);
    cmp_w(64'(nb), 64'h7, "other span");
    i_fpm_host.write_mode(64'h0000_1357_0000_0000);
    run_op(FPM_OP_MOVE);
    cmp_w(64'(nr0 - nr), 64'h1, "early ready");
    i_fpm_host.write_mode(64'h0000_1352_0010_0000);
    run_op(FPM_OP_MOVE);
    cmp_w(64'(nb), 64'h2, "pipeline span");
    cmp_w(64'(nr), 64'h3, "pipeline ready not advanced");
    $display("test timing done");
    i_fpm_host.write_mode(64'h0000_6357_0800_0000);
    faults = 6'h20;
    tick(2);
    cmp_b(summ, 1'b0, "masked fault");
    cmp_b(pin_n, 1'b1, "masked pin");
    faults = 6'h21;
    tick(2);
    cmp_b(summ, 1'b1, "summary");
    cmp_b(pin_n, 1'b0, "pin active");
    cmp_b(halted, 1'b1, "halted");
    run_op(FPM_OP_MOVE);
    cmp_w(64'(nb), 64'h0, "start while halted");
    i_fpm_host.write_mode(64'h0000_0357_0800_0000);
    cmp_b(pin_n, 1'b1, "pin gated off");
    cmp_b(halted, 1'b0, "halt off");
    faults = 6'h00;
    tick(2);
    $display("test faults done");
    complete_run();
  end
endmodule // fp_accelerator_mode_control_bench
